/* File: rtl/usb_ep_xfer.v */
// Overview of operation
// - Control transfer: setup, data stages, opposite status
// - Stall handshake aborts a control transfer
// - Status IN is zero-length with DATA1
// - Arguments follow in OUT, replies in IN
// - Setup is acked by hardware, flag set
// - Interrupt held while setup flag, if enabled
// - Transmit-ready set by firmware, cleared by hardware
// - Host ACK sets transmit-complete, frees FIFO
// - Interrupt pending while transmit-complete is set, if enabled
// - Register side and bus side clocking
// - NAK OUT data while firmware owns FIFO
`timescale 1ns/1ps
`include "usb_ep_map.vh"

module usb_ep_xfer
(
    // Clock, enable and reset.
    input wire sys_clk_in,
    input wire ce_in,
    input wire nrst_in,
    // AHB-Lite slave.
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output reg [31:0] hrdata_out,
    output wire hreadyout_out,
    output wire hresp_out,
    // Token and receive strobes from the serial engine.
    input wire tok_setup_in,
    input wire tok_out_in,
    input wire tok_in_in,
    input wire rx_valid_in,
    input wire [7:0] rx_byte_in,
    input wire rx_end_in,
    input wire host_ack_in,
    // Transmit stream to the serial engine.
    output wire tx_active_out,
    output reg tx_pid_data1_out,
    output reg tx_valid_out,
    output reg [7:0] tx_byte_out,
    input wire tx_byte_ready_in,
    output reg tx_end_out,
    // Handshakes to send.
    output reg hs_ack_out,
    output reg hs_nak_out,
    output reg hs_stall_out,
    // Interrupt and pull-up control.
    output reg irq_out,
    output wire pullup_en_out
);

    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    reg tx_complete_flag_ff; // Payload acknowledged by the host.
    reg rxdata_ff; // OUT payload waiting for firmware.
    reg setup_ff; // Setup packet waiting for firmware.
    reg stall_ff; // Answer every OUT and IN token with a stall.
    reg txrdy_ff; // Payload loaded and handed to hardware.
    reg retry_ff; // Payload sent but not yet acknowledged.
    reg toggle_ff; // Data toggle for the next IN packet.
    reg dir_ff; // Direction bit of the last setup request.
    reg wlen_nz_ff; // Last setup request carries a data stage.
    reg irq_en_ff;
    reg pullup_ff;
    reg [2:0] stage_ff;
    reg [2:0] eng_ff;
    reg [1:0] ans_ff; // Handshake chosen when the OUT token came in.
    reg [3:0] byte_idx_ff;
    reg [7:0] ack_cnt_ff;
    reg wr_pend_ff;
    reg [7:0] wr_addr_ff;

    // FIFO wiring.
    reg fifo_clr;
    reg fifo_rewind;
    reg fifo_wr;
    reg [7:0] fifo_wdata;
    reg fifo_rd;
    wire [7:0] fifo_rdata;
    wire [`FIFO_PW-1:0] fifo_count;
    wire [`FIFO_PW-1:0] fifo_left;

    // Answer codes held between token and end of packet.
    localparam [1:0] ANS_ACK = 2'h0;
    localparam [1:0] ANS_NAK = 2'h1;
    localparam [1:0] ANS_STALL = 2'h2;

    // ------------------------------------------------------------------------
    // Bus slave decode. The slave never waits, so every transfer is zero wait.
    // ------------------------------------------------------------------------
    wire addr_ok = hsel_in && htrans_in[1] && hready_in;
    wire rd_req = addr_ok && !hwrite_in;
    wire wr_req = addr_ok && hwrite_in;
    wire csr_wr = wr_pend_ff && wr_addr_ff == `EP_CSR_OFS;
    wire fdr_wr = wr_pend_ff && wr_addr_ff == `EP_FDR_OFS;
    wire cfg_wr = wr_pend_ff && wr_addr_ff == `EP_CFG_OFS;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign pullup_en_out = pullup_ff;
    assign tx_active_out = (eng_ff == `ENG_TX);

    // Firmware owns the bank when no payload is handed over and the engine rests.
    wire eng_idle = (eng_ff == `ENG_IDLE);
    wire fw_load_ok = eng_idle && !txrdy_ff && !retry_ff;
    wire fw_fifo_wr = fdr_wr && fw_load_ok;
    wire fw_fifo_rd = rd_req && haddr_in[7:0] == `EP_FDR_OFS && eng_idle && !txrdy_ff && !retry_ff;
    // OUT data is only stored when no flag still gives the bank to firmware.
    wire can_rx = !setup_ff && !rxdata_ff && !txrdy_ff && !retry_ff;
    // Clearing a pending receive flag hands an empty bank back.
    wire consumed = csr_wr && ((setup_ff && !hwdata_in[`CSR_SETUP]) || (rxdata_ff && !hwdata_in[`CSR_RXDATA]));
    wire in_ok = txrdy_ff || retry_ff;

    // Event strobes that set or clear flags, decoded from the engine.
    wire setup_done = (eng_ff == `ENG_RX_SETUP) && rx_end_in;
    wire out_done = (eng_ff == `ENG_RX_OUT) && rx_end_in;
    wire in_acked = (eng_ff == `ENG_WAIT_ACK) && host_ack_in;
    wire in_take = eng_idle && tok_in_in && !tok_setup_in && !tok_out_in && !stall_ff && txrdy_ff;

    // ------------------------------------------------------------------------
    // FIFO access arbitration. Bus traffic wins; a firmware access that meets
    // a token in the same cycle is lost, which firmware avoids by owning rules.
    // ------------------------------------------------------------------------
    always @*
    begin
        fifo_clr = 1'b0;
        fifo_rewind = 1'b0;
        fifo_wr = 1'b0;
        fifo_wdata = rx_byte_in;
        fifo_rd = 1'b0;
        case (eng_ff)
            `ENG_IDLE:
            begin
                if (tok_setup_in || (tok_out_in && can_rx && !stall_ff))
                begin
                    fifo_clr = 1'b1;
                end
                else if (tok_in_in && !stall_ff && in_ok)
                begin
                    fifo_rewind = 1'b1;
                end
                else if (consumed)
                begin
                    fifo_clr = 1'b1;
                end
                else
                begin
                    fifo_wr = fw_fifo_wr;
                    fifo_wdata = hwdata_in[7:0];
                    fifo_rd = fw_fifo_rd;
                end
            end
            `ENG_RX_SETUP, `ENG_RX_OUT:
            begin
                fifo_wr = rx_valid_in;
            end
            `ENG_TX:
            begin
                fifo_rd = (!tx_valid_out || tx_byte_ready_in) && fifo_left != {`FIFO_PW{1'b0}};
            end
            `ENG_WAIT_ACK:
            begin
                fifo_clr = host_ack_in;
            end
            default:
            begin
                fifo_clr = 1'b0;
            end
        endcase
    end

    ep_fifo u_fifo
    (
        .sys_clk_in(sys_clk_in),
        .ce_in(ce_in),
        .nrst_in(nrst_in),
        .clr_in(fifo_clr),
        .rewind_in(fifo_rewind),
        .wr_en_in(fifo_wr),
        .wr_data_in(fifo_wdata),
        .rd_en_in(fifo_rd),
        .rd_data_out(fifo_rdata),
        .count_out(fifo_count),
        .left_out(fifo_left)
    );

    // ------------------------------------------------------------------------
    // Register file. Hardware sets win over firmware clears in the same cycle.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk_in)
    begin
        if (!nrst_in)
        begin
            tx_complete_flag_ff <= 1'b0;
            rxdata_ff <= 1'b0;
            setup_ff <= 1'b0;
            stall_ff <= 1'b0;
            txrdy_ff <= 1'b0;
            irq_en_ff <= 1'b0;
            pullup_ff <= 1'b0;
            irq_out <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= `RST_BYTE;
            hrdata_out <= `RST_WORD;
        end
        else if (ce_in)
        begin
            wr_pend_ff <= wr_req;
            wr_addr_ff <= haddr_in[7:0];
            // Read data is latched in the address phase and stands in the data phase.
            if (rd_req)
            begin
                case (haddr_in[7:0])
                    `EP_CSR_OFS: hrdata_out <= {17'h0_0000, stage_ff, fifo_count, dir_ff, 2'h0,
                        txrdy_ff, stall_ff, setup_ff, rxdata_ff, tx_complete_flag_ff};
                    `EP_FDR_OFS: hrdata_out <= fw_fifo_rd ? {24'h00_0000, fifo_rdata} : `RST_WORD;
                    `EP_CFG_OFS: hrdata_out <= {23'h00_0000, pullup_ff, 7'h00, irq_en_ff};
                    default: hrdata_out <= `RST_WORD;
                endcase
            end
            tx_complete_flag_ff <= in_acked || (tx_complete_flag_ff && !(csr_wr && !hwdata_in[`CSR_TX_COMPLETE_FLAG]));
            rxdata_ff <= out_done && ans_ff == ANS_ACK || (rxdata_ff && !(csr_wr && !hwdata_in[`CSR_RXDATA]));
            setup_ff <= setup_done || (setup_ff && !(csr_wr && !hwdata_in[`CSR_SETUP]));
            // A setup packet ends any stall so the next request can proceed.
            if (setup_done)
            begin
                stall_ff <= 1'b0;
            end
            else if (csr_wr)
            begin
                stall_ff <= hwdata_in[`CSR_STALL];
            end
            // Only firmware sets it; hardware drops it when it takes the payload.
            if (setup_done)
            begin
                txrdy_ff <= 1'b0;
            end
            else
            begin
                txrdy_ff <= (txrdy_ff && !in_take) || (csr_wr && hwdata_in[`CSR_TXRDY]);
            end
            if (cfg_wr)
            begin
                irq_en_ff <= hwdata_in[`CFG_IRQ_EN];
                pullup_ff <= hwdata_in[`CFG_PULLUP];
            end
            irq_out <= irq_en_ff && (setup_ff || tx_complete_flag_ff || rxdata_ff);
        end
    end

    // ------------------------------------------------------------------------
    // Bus-side engine. The serial engine delivers its strobes already moved
    // onto this clock, so they are used here without further synchronising.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk_in)
    begin
        if (!nrst_in)
        begin
            eng_ff <= `ENG_IDLE;
            stage_ff <= `STG_IDLE;
            ans_ff <= ANS_ACK;
            retry_ff <= 1'b0;
            toggle_ff <= 1'b0;
            dir_ff <= 1'b0;
            wlen_nz_ff <= 1'b0;
            byte_idx_ff <= 4'h0;
            ack_cnt_ff <= 8'h00;
            tx_pid_data1_out <= 1'b0;
            tx_valid_out <= 1'b0;
            tx_byte_out <= `RST_BYTE;
            tx_end_out <= 1'b0;
            hs_ack_out <= 1'b0;
            hs_nak_out <= 1'b0;
            hs_stall_out <= 1'b0;
        end
        else if (ce_in)
        begin
            tx_end_out <= 1'b0;
            hs_ack_out <= 1'b0;
            hs_nak_out <= 1'b0;
            hs_stall_out <= 1'b0;
            case (eng_ff)
                `ENG_IDLE:
                begin
                    byte_idx_ff <= 4'h0;
                    if (tok_setup_in)
                    begin
                        eng_ff <= `ENG_RX_SETUP;
                        wlen_nz_ff <= 1'b0;
                        retry_ff <= 1'b0;
                    end
                    else if (tok_out_in)
                    begin
                        eng_ff <= (can_rx && !stall_ff) ? `ENG_RX_OUT : `ENG_RX_DROP;
                        ans_ff <= stall_ff ? ANS_STALL : (can_rx ? ANS_ACK : ANS_NAK);
                        if (stage_ff == `STG_DATA_IN)
                        begin
                            stage_ff <= `STG_STAT_OUT;
                        end
                    end
                    else if (tok_in_in)
                    begin
                        if (stall_ff)
                        begin
                            hs_stall_out <= 1'b1;
                        end
                        else if (in_ok)
                        begin
                            eng_ff <= `ENG_TX;
                            retry_ff <= 1'b1;
                            // The status IN packet always goes out as DATA1.
                            tx_pid_data1_out <= toggle_ff || stage_ff == `STG_STAT_IN ||
                                stage_ff == `STG_DATA_OUT;
                            if (stage_ff == `STG_DATA_OUT)
                            begin
                                stage_ff <= `STG_STAT_IN;
                            end
                        end
                        else
                        begin
                            hs_nak_out <= 1'b1;
                        end
                    end
                end
                `ENG_RX_SETUP, `ENG_RX_OUT, `ENG_RX_DROP:
                begin
                    if (rx_valid_in && byte_idx_ff != 4'hf)
                    begin
                        byte_idx_ff <= byte_idx_ff + 4'h1;
                    end
                    // Capture direction and whether a data stage follows.
                    if (rx_valid_in && eng_ff == `ENG_RX_SETUP)
                    begin
                        if (byte_idx_ff == 4'h0)
                        begin
                            dir_ff <= rx_byte_in[7];
                        end
                        if ((byte_idx_ff == 4'h6 || byte_idx_ff == 4'h7) && rx_byte_in != 8'h00)
                        begin
                            wlen_nz_ff <= 1'b1;
                        end
                    end
                    if (rx_end_in)
                    begin
                        eng_ff <= `ENG_IDLE;
                        if (eng_ff == `ENG_RX_SETUP)
                        begin
                            hs_ack_out <= 1'b1;
                            toggle_ff <= 1'b1;
                            stage_ff <= !wlen_nz_ff ? `STG_STAT_IN : (dir_ff ? `STG_DATA_IN : `STG_DATA_OUT);
                        end
                        else
                        begin
                            hs_ack_out <= (ans_ff == ANS_ACK);
                            hs_nak_out <= (ans_ff == ANS_NAK);
                            hs_stall_out <= (ans_ff == ANS_STALL);
                            if (ans_ff == ANS_ACK && stage_ff == `STG_STAT_OUT)
                            begin
                                stage_ff <= `STG_IDLE;
                            end
                        end
                    end
                end
                `ENG_TX:
                begin
                    if (tx_valid_out && !tx_byte_ready_in)
                    begin
                        tx_valid_out <= 1'b1;
                    end
                    else if (fifo_left != {`FIFO_PW{1'b0}})
                    begin
                        tx_byte_out <= fifo_rdata;
                        tx_valid_out <= 1'b1;
                    end
                    else
                    begin
                        tx_valid_out <= 1'b0;
                        tx_end_out <= 1'b1;
                        ack_cnt_ff <= 8'h00;
                        eng_ff <= `ENG_WAIT_ACK;
                    end
                end
                `ENG_WAIT_ACK:
                begin
                    ack_cnt_ff <= ack_cnt_ff + 8'h01;
                    if (host_ack_in)
                    begin
                        eng_ff <= `ENG_IDLE;
                        retry_ff <= 1'b0;
                        toggle_ff <= !tx_pid_data1_out;
                        if (stage_ff == `STG_STAT_IN)
                        begin
                            stage_ff <= `STG_IDLE;
                        end
                    end
                    else if (ack_cnt_ff == `ACK_WAIT_CYC)
                    begin
                        // No handshake: keep the payload for a retry.
                        eng_ff <= `ENG_IDLE;
                    end
                end
                default:
                begin
                    eng_ff <= `ENG_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: rtl/usb_ep_map.vh */
`ifndef USB_EP_MAP_VH
`define USB_EP_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets on the AHB-Lite slave.
// ----------------------------------------------------------------------------
`define EP_CSR_OFS 8'h00
`define EP_FDR_OFS 8'h04
`define EP_CFG_OFS 8'h08

// ----------------------------------------------------------------------------
// Field positions of the endpoint control and status register.
// ----------------------------------------------------------------------------
`define CSR_TX_COMPLETE_FLAG 0
`define CSR_RXDATA 1
`define CSR_SETUP 2
`define CSR_STALL 3
`define CSR_TXRDY 4
`define CSR_DIR 7
`define CSR_CNT_LSB 8
`define CSR_STAGE_LSB 12

// ----------------------------------------------------------------------------
// Field positions of the configuration register.
// ----------------------------------------------------------------------------
`define CFG_IRQ_EN 0
`define CFG_PULLUP 8

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define RST_WORD 32'h0000_0000
`define RST_BYTE 8'h00

// ----------------------------------------------------------------------------
// FIFO geometry: one bank of eight bytes.
// ----------------------------------------------------------------------------
`define FIFO_DEPTH 8
`define FIFO_PW 4

// ----------------------------------------------------------------------------
// Control transfer stages.
// ----------------------------------------------------------------------------
`define STG_IDLE 3'h0
`define STG_DATA_IN 3'h1
`define STG_DATA_OUT 3'h2
`define STG_STAT_IN 3'h3
`define STG_STAT_OUT 3'h4

// ----------------------------------------------------------------------------
// Bus-side engine states.
// ----------------------------------------------------------------------------
`define ENG_IDLE 3'h0
`define ENG_RX_SETUP 3'h1
`define ENG_RX_OUT 3'h2
`define ENG_RX_DROP 3'h3
`define ENG_TX 3'h4
`define ENG_WAIT_ACK 3'h5

// ----------------------------------------------------------------------------
// Timing: longest wait for the host handshake after a data IN packet.
// ----------------------------------------------------------------------------
`define CLK_MHZ 125
`define ACK_WAIT_NS 1500
`define ACK_WAIT_CYC ((`ACK_WAIT_NS * `CLK_MHZ) / 1000)

`endif

/* File: rtl/ep_fifo.v */
`timescale 1ns/1ps
`include "usb_ep_map.vh"

// Single-bank byte store with a write pointer and an independent read pointer.
module ep_fifo
(
    // Clock, enable and reset.
    input wire sys_clk_in,
    input wire ce_in,
    input wire nrst_in,
    // Pointer control.
    input wire clr_in,
    input wire rewind_in,
    // Write side.
    input wire wr_en_in,
    input wire [7:0] wr_data_in,
    // Read side.
    input wire rd_en_in,
    output wire [7:0] rd_data_out,
    output wire [`FIFO_PW-1:0] count_out,
    output wire [`FIFO_PW-1:0] left_out
);

    // Storage and pointers.
    reg [7:0] mem_ff [0:`FIFO_DEPTH-1];
    reg [`FIFO_PW-1:0] wr_ptr_ff;
    reg [`FIFO_PW-1:0] rd_ptr_ff;

    // Bytes come back in the order they went in.
    assign rd_data_out = mem_ff[rd_ptr_ff[`FIFO_PW-2:0]];
    assign count_out = wr_ptr_ff;
    assign left_out = wr_ptr_ff - rd_ptr_ff;

    // ------------------------------------------------------------------------
    // Pointer update; writes beyond the bank size are dropped, not wrapped.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk_in)
    begin
        if (!nrst_in)
        begin
            wr_ptr_ff <= {`FIFO_PW{1'b0}};
            rd_ptr_ff <= {`FIFO_PW{1'b0}};
        end
        else if (ce_in)
        begin
            if (clr_in)
            begin
                wr_ptr_ff <= {`FIFO_PW{1'b0}};
                rd_ptr_ff <= {`FIFO_PW{1'b0}};
            end
            else
            begin
                if (wr_en_in && wr_ptr_ff != `FIFO_DEPTH)
                begin
                    wr_ptr_ff <= wr_ptr_ff + 1'b1;
                end
                if (rewind_in)
                begin
                    rd_ptr_ff <= {`FIFO_PW{1'b0}};
                end
                else if (rd_en_in && rd_ptr_ff != wr_ptr_ff)
                begin
                    rd_ptr_ff <= rd_ptr_ff + 1'b1;
                end
            end
        end
    end

    // Memory array carries no reset; only the pointers define its content.
    always @(posedge sys_clk_in)
    begin
        if (ce_in && !clr_in && wr_en_in && wr_ptr_ff != `FIFO_DEPTH)
        begin
            mem_ff[wr_ptr_ff[`FIFO_PW-2:0]] <= wr_data_in;
        end
    end

endmodule

/* File: tb/usb_ep_xfer_sva.sv */
`timescale 1ns/1ps
module usb_ep_xfer_sva
(
    // Clock, reset and bus request.
    input wire sys_clk_in, input wire nrst_in, input wire hsel_in, input wire [1:0] htrans_in, input wire hwrite_in,
    // Token side.
    input wire tok_setup_in, input wire tok_in_in, input wire rx_end_in, input wire tx_byte_ready_in,
    // Watched outputs.
    input wire tx_active_out, input wire tx_valid_out, input wire [7:0] tx_byte_out, input wire tx_end_out,
    input wire hs_ack_out, input wire hs_nak_out, input wire hs_stall_out, input wire irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // A write address phase seen last cycle; irq may only drop after firmware writes.
    reg wr_ff;
    // Open setup packet, so its end is known to need a hardware handshake.
    reg seen_ff;
    always @(posedge sys_clk_in)
    begin
        wr_ff <= nrst_in & hsel_in & htrans_in[1] & hwrite_in;
        seen_ff <= nrst_in & (tok_setup_in | (seen_ff & ~rx_end_in));
    end
    a_setup_ack: assert property (rx_end_in && seen_ff |=> hs_ack_out) else $error("setup not acked");
    a_ack_pulse: assert property (hs_ack_out |=> !hs_ack_out) else $error("ack too long");
    a_in_answer: assert property (tok_in_in && !tx_active_out |=> hs_nak_out || hs_stall_out || tx_active_out)
        else $error("in token unanswered");
    a_hs_single: assert property ($onehot0({hs_ack_out, hs_nak_out, hs_stall_out})) else $error("two handshakes");
    a_tx_start: assert property ($rose(tx_active_out) |-> ##[1:2] (tx_valid_out || tx_end_out))
        else $error("payload not sent");
    a_tx_hold: assert property (tx_valid_out && !tx_byte_ready_in |=> tx_valid_out && $stable(tx_byte_out))
        else $error("byte dropped");
    a_end_clean: assert property (tx_end_out |-> !tx_valid_out ##1 !tx_end_out) else $error("bad end");
    a_irq_hold: assert property ($fell(irq_out) |-> $past(wr_ff, 2)) else $error("irq dropped alone");
endmodule
bind usb_ep_xfer usb_ep_xfer_sva i_sva (.sys_clk_in, .nrst_in, .hsel_in, .htrans_in, .hwrite_in, .tok_setup_in,
    .tok_in_in, .rx_end_in, .tx_byte_ready_in, .tx_active_out, .tx_valid_out, .tx_byte_out, .tx_end_out,
    .hs_ack_out, .hs_nak_out, .hs_stall_out, .irq_out);

/* File: tb/usb_host_model.sv */
`timescale 1ns/1ps
module usb_host_model
(
    // Clock and reset.
    input wire clk_in,
    input wire nrst_in,
    // Stream from the endpoint.
    input wire tx_valid_in,
    input wire [7:0] tx_byte_in,
    input wire tx_end_in,
    // Host replies.
    output reg tx_byte_ready_out,
    output reg host_ack_out
);
    // Bytes seen on the wire, in bus order.
    logic [7:0] got[$];
    // Delay from packet end to the host handshake.
    reg [2:0] dly_ff;
    // Ready toggles so the endpoint sees both prompt and slow takes.
    always @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            tx_byte_ready_out <= 1'b0;
            host_ack_out <= 1'b0;
            dly_ff <= 3'h0;
        end
        else
        begin
            tx_byte_ready_out <= ~tx_byte_ready_out;
            if (tx_valid_in && tx_byte_ready_out)
                got.push_back(tx_byte_in);
            host_ack_out <= (dly_ff == 3'h1);
            dly_ff <= tx_end_in ? 3'h4 : dly_ff - {2'h0, dly_ff != 3'h0};
        end
    end
endmodule

/* File: tb/usb_ep_xfer_tb.sv */
`timescale 1ns/1ps
module usb_ep_xfer_tb;
    // Port stimulus.
    reg sys_clk_in, nrst_in = 0, hsel_in = 0, hwrite_in = 0, rx_valid_in = 0;
    reg tok_setup_in = 0, tok_out_in = 0, tok_in_in = 0, rx_end_in = 0;
    reg [1:0] htrans_in = 0;
    reg [31:0] haddr_in = 0, hwdata_in = 0, rd;
    reg [7:0] rx_byte_in = 0;
    wire ce_in = 1'b1;
    wire [2:0] hsize_in = 3'h2;
    wire hready_in, tx_byte_ready_in, host_ack_in, hreadyout_out, hresp_out, tx_active_out, tx_pid_data1_out;
    wire tx_valid_out, tx_end_out, hs_ack_out, hs_nak_out, hs_stall_out, irq_out, pullup_en_out;
    wire [31:0] hrdata_out;
    wire [7:0] tx_byte_out;
    integer failures = 0, total_checks = 0, i, k;
    // Register rows: offset, value written, value read back.
    reg [71:0] rows[0:4] = '{{8'h08, 32'h0000_0101, 32'h0000_0101}, {8'h0C, 32'hFFFF_FFFF, 32'h0000_0000},
        {8'h00, 32'h0000_0008, 32'h0000_0008}, {8'h00, 32'h0000_0000, 32'h0000_0000},
        {8'h08, 32'h0000_0100, 32'h0000_0100}};
    // The single slave drives the bus ready.
    assign hready_in = hreadyout_out;
    usb_ep_xfer i_dut (.*);
    usb_host_model i_host (.clk_in(sys_clk_in), .nrst_in(nrst_in), .tx_valid_in(tx_valid_out),
        .tx_byte_in(tx_byte_out), .tx_end_in(tx_end_out), .tx_byte_ready_out(tx_byte_ready_in),
        .host_ack_out(host_ack_in));
    initial
    begin
        sys_clk_in = 0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    task summarize;
    begin
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    // One single AHB transfer; each phase waits, bounded, for hready.
    task bus(input [7:0] a, input w, input [31:0] d);
        integer ph, n;
    begin
        @(posedge sys_clk_in);
        {hsel_in, htrans_in, haddr_in, hwrite_in} <= {3'b110, 24'h0, a, w};
        for (ph = 0; ph < 2; ph++)
        begin
            n = 0;
            do begin @(posedge sys_clk_in); n++; end while (hreadyout_out !== 1'b1 && n < 20);
            if (n >= 20)
            begin
                failures++;
                summarize;
            end
            if (ph == 0)
                {hsel_in, htrans_in, hwdata_in} <= {3'b000, d};
        end
        rd = hrdata_out;
    end
    endtask
    // One-cycle strobes.
    task ev(input [3:0] v);
    begin
        @(posedge sys_clk_in);
        {rx_end_in, tok_in_in, tok_out_in, tok_setup_in, rx_valid_in} <= {v, 1'b0};
        @(posedge sys_clk_in);
        {rx_end_in, tok_in_in, tok_out_in, tok_setup_in} <= 4'h0;
        #1;
    end
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk_in);
        nrst_in <= 1;
        for (i = 0; i < 5; i++)
        begin
            bus(rows[i][71:64], 1, rows[i][63:32]);
            bus(rows[i][71:64], 0, 0);
            chk("reg", rows[i][31:0], rd);
        end
        chk("pullup", 1, pullup_en_out);
        // Mid-run reset must clear the configuration.
        nrst_in <= 0;
        repeat (8) @(posedge sys_clk_in);
        nrst_in <= 1;
        bus(8'h08, 0, 0);
        chk("cfg", 0, rd);
        chk("pullup", 0, pullup_en_out);
        bus(8'h08, 1, 32'h0000_0101);
        // Setup packet: device to host, with a data stage.
        ev(4'h1);
        for (i = 0; i < 8; i++)
            @(posedge sys_clk_in) {rx_valid_in, rx_byte_in} <= {1'b1, i ? {i[3:0], i[3:0]} : 8'h80};
        ev(4'h8);
        chk("ack", 1, hs_ack_out);
        bus(8'h00, 0, 0);
        chk("csr", 32'h0000_1884, rd);
        chk("irq", 1, irq_out);
        for (i = 0; i < 8; i++)
        begin
            bus(8'h04, 0, 0);
            chk("fifo", i ? {i[3:0], i[3:0]} : 8'h80, rd);
        end
        bus(8'h00, 1, 0);
        bus(8'h00, 0, 0);
        chk("irq", 0, irq_out);
        // Two-byte data IN packet.
        bus(8'h04, 1, 8'hA5);
        bus(8'h04, 1, 8'h3C);
        bus(8'h00, 1, 32'h0000_0010);
        ev(4'h4);
        chk("pid", 1, tx_pid_data1_out);
        rd = 0;
        for (k = 0; k < 30 && rd[0] !== 1'b1; k++)
            bus(8'h00, 0, 0);
        chk("tx_complete_flag", 1, rd[0]);
        chk("txrdy", 0, rd[4]);
        chk("bytes", 16'hA53C, {i_host.got[0], i_host.got[1]});
        chk("irq", 1, irq_out);
        bus(8'h00, 1, 0);
        ev(4'h2);
        ev(4'h8);
        chk("ack", 1, hs_ack_out);
        ev(4'h4);
        chk("nak", 1, hs_nak_out);
        bus(8'h00, 1, 32'h0000_0008);
        ev(4'h4);
        chk("stall", 1, hs_stall_out);
        summarize;
    end
endmodule
